// File: design/bisr_map.svh
// Purpose: Offsets, reset values, codes and timing of the bridge register bank
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef BISR_MAP_SVH
`define BISR_MAP_SVH

// ----------------------------------------------------------------
// Commands and register offsets
// ----------------------------------------------------------------
`define BISR_CMD_WRITE   8'h20
`define BISR_CMD_READ    8'h21
`define BISR_OFS_PINS    8'h01
`define BISR_OFS_CLKDIV  8'h02
`define BISR_OFS_STATUS  8'h03
`define BISR_OFS_TIMEOUT 8'h04
`define BISR_OFS_OWNADR  8'h05

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define BISR_RST_PINS    6'h3F
`define BISR_RST_CLKDIV  8'h19
`define BISR_RST_TIMEOUT 8'hFE
`define BISR_RST_OWNADR  8'h00
`define BISR_TMO_EN_BIT  0
`define BISR_TOV_MSB     7
`define BISR_TOV_LSB     1
`define BISR_TOC_ONES    9'h1FF
`define BISR_DIV_MIN     8'h05
`define BISR_CFG_INPUT   2'h1
`define BISR_CFG_PUSH    2'h2

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define BISR_ST_OK       8'hF0
`define BISR_ST_ADRNACK  8'hF1
`define BISR_ST_DATNACK  8'hF2
`define BISR_ST_BUSY     8'hF3
`define BISR_ST_TIMEOUT  8'hF8
`define BISR_ST_BADCNT   8'hF9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BISR_SYS_HZ      25000000
`define BISR_TB_HZ       57600

`endif

// File: design/bisr_pkg.sv
// Purpose: Types shared by the bridge register bank
// Assumes: Nothing
// Notes:   Constants live in bisr_map.svh
package bisr_pkg;

	typedef enum logic [2:0] {
		PS_CMD,
		PS_WR_ADDR,
		PS_WR_DATA,
		PS_RD_ADDR,
		PS_RD_DUMMY,
		PS_IGNORE
	} bisr_parse_t;

	typedef logic [7:0] bisr_byte_t;

endpackage

// File: design/bisr_timebase.sv
// Purpose: Time-out time base, one tick per period of the slow clock
// Assumes: sys_clk at BISR_SYS_HZ
// Notes:   Period rounded down to whole cycles
`timescale 1ns/100ps
`include "bisr_map.svh"

module bisr_timebase #(
	parameter int TICK_DIV = `BISR_SYS_HZ / `BISR_TB_HZ
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	output logic      tick
);

	localparam int CW = $clog2(TICK_DIV);

	generate
		if (TICK_DIV < 16) begin : g_bad
			$error("bisr_timebase: TICK_DIV below 16");
		end
	endgenerate

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_tick;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count + 1'b1;
		next_tick  = 1'b0;
		if (count == CW'(TICK_DIV - 1)) begin
			next_count = '0;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick |=> (!tick)[*8]) else $error("time base ticks too close");

endmodule // bisr_timebase

// File: design/bisr_timeout.sv
// Purpose: 16-bit time-out down counter of one bus transaction
// Assumes: tick comes from bisr_timebase
// Notes:   expired is a one-cycle pulse
`timescale 1ns/100ps
`include "bisr_map.svh"

module bisr_timeout (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       load,
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic       timeoutEnable,
	input  wire logic [6:0] timeoutValue,
	output logic            expired
);

	logic [15:0] count;
	logic [15:0] next_count;
	logic        armed;
	logic        next_armed;
	logic        next_expired;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb begin
		next_count   = count;
		next_armed   = armed;
		next_expired = 1'b0;
		if (load) begin
			next_count = {timeoutValue, `BISR_TOC_ONES};
			next_armed = 1'b1;
		end else if (!run) begin
			next_armed = 1'b0;
		end else if (armed && tick) begin
			if (count != 16'h0000) begin
				next_count = count - 16'h0001;
			end else if (timeoutEnable) begin
				next_expired = 1'b1;
				next_armed   = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count   <= 16'h0000;
			armed   <= 1'b0;
			expired <= 1'b0;
		end else begin
			count   <= next_count;
			armed   <= next_armed;
			expired <= next_expired;
		end
	end

	a_load_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
		load |=> count == {$past(timeoutValue), `BISR_TOC_ONES}) else $error("time-out load value wrong");

	a_expire_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
		expired |-> $past(timeoutEnable) && $past(count) == 16'h0000) else $error("expiry without cause");

endmodule // bisr_timeout

// File: design/bisr_regs.sv
// Purpose: Register bank of a serial-to-bus bridge: pins, own address, clock divider,
//          time-out and transfer result, reached by single-register commands
// Assumes: Byte stream from the serial slave shifter, synchronous to sys_clk
// Notes:   Interrupt output is active low and held until the result is read
//
// How it works
// - Pin register reads live pin levels
// - Written bits drive only output-configured pins
// - Bits 5:4 fixed pins, 3:0 programmable
// - Own address register, MSB sent first
// - Divider sets bus clock, 5 to 255
// - Time-out bit 0 enables, 7:1 value
// - Value limits transfer time before interrupt
// - Counter ticks from 57.6 kHz time base
// - 16-bit counter: nine ones, seven value bits
// - Lost arbitration restarts when bus free
// - Expiry asserts interrupt, shows time-out code
// - Time-out covers arbitration and clock stretching
// - Success code sets interrupt; reset code silent
// - Address not acknowledged code with interrupt
// - Data not acknowledged code with interrupt
// - Busy code, no interrupt, host waits
// - Invalid byte count code with interrupt
// - Write: command, address, data byte
// - Read: command, address, dummy; data returned
`timescale 1ns/100ps
`include "bisr_map.svh"

module bisr_regs #(
	parameter int TICK_DIV = `BISR_SYS_HZ / `BISR_TB_HZ
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       frameActive,
	input  wire logic       rxValid,
	input  wire logic [7:0] rxByte,
	output logic [7:0]      txByte,
	output logic            txValid,
	input  wire logic [5:0] pinIn,
	output logic [5:0]      pinOut,
	output logic [5:0]      pinOe,
	input  wire logic [7:0] pinConfig,
	input  wire logic       xferStart,
	input  wire logic       xferDone,
	input  wire logic       addrNack,
	input  wire logic       dataNack,
	input  wire logic       badCount,
	input  wire logic       arbLost,
	input  wire logic       busFree,
	output logic            restartReq,
	output logic            timeoutAbort,
	output logic            transferBusy,
	output logic [7:0]      clockDivider,
	output logic [7:0]      ownAddress,
	output logic            intr_n
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Output enable of one pin for its type and latch
	function automatic logic pinDrives(input logic [1:0] cfg, input logic latch);
		logic d;
		d = 1'b0;
		case (cfg)
			`BISR_CFG_INPUT: d = 1'b0;
			`BISR_CFG_PUSH:  d = 1'b1;
			default:         d = ~latch;
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bisr_pkg::bisr_parse_t parse;
	bisr_pkg::bisr_parse_t next_parse;
	bisr_pkg::bisr_byte_t  regAddr;
	bisr_pkg::bisr_byte_t  next_regAddr;
	bisr_pkg::bisr_byte_t  next_txByte;
	logic                  next_txValid;
	logic [5:0]            pinLatch;
	logic [5:0]            next_pinLatch;
	logic [7:0]            divReg;
	logic [7:0]            next_divReg;
	logic [7:0]            toReg;
	logic [7:0]            next_toReg;
	logic [7:0]            adrReg;
	logic [7:0]            next_adrReg;
	logic [7:0]            status;
	logic [7:0]            next_status;
	logic                  intPending;
	logic                  next_intPending;
	logic                  busyR;
	logic                  next_busyR;
	logic                  arbPending;
	logic                  next_arbPending;
	logic                  statusRead;
	logic                  tick;
	logic                  expired;

	// ----------------------------------------------------------------
	// Time-out
	// ----------------------------------------------------------------
	bisr_timebase #(
		.TICK_DIV (TICK_DIV)
	) u_timebase (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.tick    (tick)
	);

	bisr_timeout u_timeout (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.load          (xferStart),
		.run           (busyR),
		.tick          (tick),
		.timeoutEnable (toReg[`BISR_TMO_EN_BIT]),
		.timeoutValue  (toReg[`BISR_TOV_MSB:`BISR_TOV_LSB]),
		.expired       (expired)
	);

	// ----------------------------------------------------------------
	// Command parser and register access
	// ----------------------------------------------------------------
	always_comb begin
		next_parse    = parse;
		next_regAddr  = regAddr;
		next_txByte   = txByte;
		next_txValid  = 1'b0;
		next_pinLatch = pinLatch;
		next_divReg   = divReg;
		next_toReg    = toReg;
		next_adrReg   = adrReg;
		statusRead    = 1'b0;
		if (!frameActive) begin
			next_parse = bisr_pkg::PS_CMD;
		end else if (rxValid) begin
			case (parse)
				bisr_pkg::PS_CMD: begin
					if (rxByte == `BISR_CMD_WRITE) begin
						next_parse = bisr_pkg::PS_WR_ADDR;
					end else if (rxByte == `BISR_CMD_READ) begin
						next_parse = bisr_pkg::PS_RD_ADDR;
					end else begin
						next_parse = bisr_pkg::PS_IGNORE;
					end
				end
				bisr_pkg::PS_WR_ADDR: begin
					next_regAddr = rxByte;
					next_parse   = bisr_pkg::PS_WR_DATA;
				end
				bisr_pkg::PS_WR_DATA: begin
					case (regAddr)
						`BISR_OFS_PINS:    next_pinLatch = rxByte[5:0];
						`BISR_OFS_CLKDIV:  next_divReg   = rxByte;
						`BISR_OFS_TIMEOUT: next_toReg    = rxByte;
						`BISR_OFS_OWNADR:  next_adrReg   = rxByte;
						default:           next_divReg   = divReg;
					endcase
					// One register per frame, no address increment
					next_parse = bisr_pkg::PS_IGNORE;
				end
				bisr_pkg::PS_RD_ADDR: begin
					next_txValid = 1'b1;
					case (rxByte)
						`BISR_OFS_PINS:    next_txByte = {2'b00, pinIn};
						`BISR_OFS_CLKDIV:  next_txByte = divReg;
						`BISR_OFS_TIMEOUT: next_txByte = toReg;
						`BISR_OFS_OWNADR:  next_txByte = adrReg;
						`BISR_OFS_STATUS: begin
							next_txByte = status;
							statusRead  = 1'b1;
						end
						default:           next_txByte = 8'h00;
					endcase
					next_parse = bisr_pkg::PS_RD_DUMMY;
				end
				bisr_pkg::PS_RD_DUMMY: next_parse = bisr_pkg::PS_IGNORE;
				bisr_pkg::PS_IGNORE:   next_parse = bisr_pkg::PS_IGNORE;
				default:               next_parse = bisr_pkg::PS_CMD;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			parse    <= bisr_pkg::PS_CMD;
			regAddr  <= 8'h00;
			txByte   <= 8'h00;
			txValid  <= 1'b0;
			pinLatch <= `BISR_RST_PINS;
			divReg   <= `BISR_RST_CLKDIV;
			toReg    <= `BISR_RST_TIMEOUT;
			adrReg   <= `BISR_RST_OWNADR;
		end else begin
			parse    <= next_parse;
			regAddr  <= next_regAddr;
			txByte   <= next_txByte;
			txValid  <= next_txValid;
			pinLatch <= next_pinLatch;
			divReg   <= next_divReg;
			toReg    <= next_toReg;
			adrReg   <= next_adrReg;
		end
	end

	// ----------------------------------------------------------------
	// Pins and engine settings
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_prog
			assign pinOe[gi] = pinDrives(pinConfig[2*gi+1:2*gi], pinLatch[gi]);
		end
	endgenerate

	// Fixed pins are always quasi-bidirectional
	assign pinOe[4]     = ~pinLatch[4];
	assign pinOe[5]     = ~pinLatch[5];
	assign pinOut       = pinLatch;
	assign ownAddress   = adrReg;
	// Values below the minimum are served at the minimum
	assign clockDivider = (divReg < `BISR_DIV_MIN) ? `BISR_DIV_MIN : divReg;

	// ----------------------------------------------------------------
	// Transfer result and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		next_status     = status;
		next_busyR      = busyR;
		next_arbPending = arbPending;
		next_intPending = intPending;
		if (statusRead) begin
			next_intPending = 1'b0;
		end
		if (xferStart) begin
			next_status = `BISR_ST_BUSY;
			next_busyR  = 1'b1;
		end
		if (arbLost) begin
			next_arbPending = 1'b1;
		end else if (restartReq) begin
			next_arbPending = 1'b0;
		end
		// Events win over a clear in the same cycle
		if (expired) begin
			next_status     = `BISR_ST_TIMEOUT;
			next_intPending = 1'b1;
			next_busyR      = 1'b0;
			next_arbPending = 1'b0;
		end else if (badCount) begin
			next_status     = `BISR_ST_BADCNT;
			next_intPending = 1'b1;
			next_busyR      = 1'b0;
		end else if (addrNack) begin
			next_status     = `BISR_ST_ADRNACK;
			next_intPending = 1'b1;
			next_busyR      = 1'b0;
		end else if (dataNack) begin
			next_status     = `BISR_ST_DATNACK;
			next_intPending = 1'b1;
			next_busyR      = 1'b0;
		end else if (xferDone) begin
			next_status     = `BISR_ST_OK;
			next_intPending = 1'b1;
			next_busyR      = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status     <= `BISR_ST_OK;
			busyR      <= 1'b0;
			arbPending <= 1'b0;
			intPending <= 1'b0;
		end else begin
			status     <= next_status;
			busyR      <= next_busyR;
			arbPending <= next_arbPending;
			intPending <= next_intPending;
		end
	end

	assign restartReq   = arbPending && busFree && !expired;
	assign timeoutAbort = expired;
	assign transferBusy = busyR;
	assign intr_n       = ~intPending;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	logic noEvent;
	assign noEvent = !expired && !badCount && !addrNack && !dataNack && !xferDone;

	a_pin_read_live: assert property (frameActive && rxValid && parse == bisr_pkg::PS_RD_ADDR
		&& rxByte == `BISR_OFS_PINS |=> txValid && txByte == {2'b00, $past(pinIn)})
		else $error("pin read not live");
	a_pin_write_latch: assert property (frameActive && rxValid && parse == bisr_pkg::PS_WR_DATA
		&& regAddr == `BISR_OFS_PINS |=> pinOut == $past(rxByte[5:0]))
		else $error("pin write lost");
	a_input_only_off: assert property (pinConfig[1:0] == `BISR_CFG_INPUT |-> !pinOe[0])
		else $error("input-only pin driven");
	a_timeout_code: assert property (expired |=> status == `BISR_ST_TIMEOUT && !intr_n)
		else $error("time-out not reported");
	a_done_code: assert property (xferDone && !expired && !badCount && !addrNack && !dataNack
		|=> status == `BISR_ST_OK && !intr_n && !transferBusy)
		else $error("success not reported");
	a_addr_nack: assert property (addrNack && !expired && !badCount |=> status == `BISR_ST_ADRNACK && !intr_n)
		else $error("address nack not reported");
	a_data_nack: assert property (dataNack && !expired && !badCount && !addrNack
		|=> status == `BISR_ST_DATNACK && !intr_n)
		else $error("data nack not reported");
	a_busy_quiet: assert property (xferStart && noEvent && intr_n && !statusRead
		|=> status == `BISR_ST_BUSY && intr_n && transferBusy)
		else $error("busy state wrong");
	a_bad_count: assert property (badCount && !expired |=> status == `BISR_ST_BADCNT && !intr_n)
		else $error("bad count not reported");
	a_restart_gate: assert property (restartReq |-> busFree && !expired && arbPending)
		else $error("restart while not allowed");
	a_int_release: assert property (statusRead && noEvent && !badCount |=> intr_n)
		else $error("interrupt not released");
	a_int_hold: assert property (!intr_n && !statusRead |=> !intr_n)
		else $error("interrupt dropped early");
	a_div_floor: assert property (clockDivider >= `BISR_DIV_MIN)
		else $error("divider below minimum");

	c_reg_write: cover property (parse == bisr_pkg::PS_WR_DATA && rxValid && frameActive);
	c_reg_read:  cover property (txValid);
	c_timeout:   cover property (expired);
	c_restart:   cover property (restartReq);

endmodule // bisr_regs

// File: tb/bisr_engine_model.sv
// Purpose: Behavioural bus engine facing the register bank
// Assumes: Driven from the bench by go, kind and dly
// Notes:   Kinds 0 done, 1 addr nack, 2 data nack, 3 bad count, 4 hang, 5 finish, 6 arb lost
`timescale 1ns/100ps

module bisr_engine_model (
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [2:0] kind,
	input  wire logic [7:0] dly,
	output logic            xferStart,
	output logic            xferDone,
	output logic            addrNack,
	output logic            dataNack,
	output logic            badCount,
	output logic            arbLost,
	output logic            busFree
);
	initial begin
		{xferStart, xferDone, addrNack, dataNack, badCount, arbLost} = 6'h00;
		busFree = 1'b1;
	end

	always begin
		@(posedge sys_clk);
		if (go === 1'b1) begin
			@(negedge sys_clk);
			if (kind == 3'h6) begin
				// Bus held by another master for dly+1 cycles: the lost-arbitration cycle, then dly more
				busFree = 1'b0;
				arbLost = 1'b1;
				@(negedge sys_clk);
				arbLost = 1'b0;
				repeat (dly) @(negedge sys_clk);
				busFree = 1'b1;
			end else begin
				if (kind != 3'h5) begin
					xferStart = 1'b1;
					@(negedge sys_clk);
					xferStart = 1'b0;
				end
				// Kind 4 models a slave stretching the clock forever
				if (kind != 3'h4) begin
					repeat (dly) @(negedge sys_clk);
					xferDone = (kind == 3'h0) || (kind == 3'h5);
					addrNack = (kind == 3'h1);
					dataNack = (kind == 3'h2);
					badCount = (kind == 3'h3);
					@(negedge sys_clk);
					{xferDone, addrNack, dataNack, badCount} = 4'h0;
				end
			end
		end
	end
endmodule // bisr_engine_model

// File: tb/test_bisr_regs.sv
// Purpose: Self-checking bench of the bridge register bank
// Assumes: TICK_DIV shortened to 16 cycles
// Notes:   Pin levels resolved from design enables and an external level
`timescale 1ns/100ps
`include "bisr_map.svh"

module test_bisr_regs;
	localparam int TD = 16;
	logic       sys_clk, reset_n, frameActive, rxValid, go;
	logic [7:0] rxByte, pinConfig, dly, rdData, rnd, d, txByte, clockDivider, ownAddress;
	logic [5:0] extLevel, pinOut, pinOe;
	wire  [5:0] pinIn;
	logic [2:0] kind;
	logic       txValid, restartReq, timeoutAbort, transferBusy, intr_n;
	logic       xferStart, xferDone, addrNack, dataNack, badCount, arbLost, busFree;
	logic [7:0] codes [4] = '{`BISR_ST_OK, `BISR_ST_ADRNACK, `BISR_ST_DATNACK, `BISR_ST_BADCNT};
	int         failures, n_checks, cnt, rdCnt, abortCnt, restartSeen, badRestart;

	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

	bisr_regs #(.TICK_DIV(TD)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .frameActive(frameActive),
		.rxValid(rxValid), .rxByte(rxByte), .txByte(txByte), .txValid(txValid), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pinConfig(pinConfig), .xferStart(xferStart), .xferDone(xferDone),
		.addrNack(addrNack), .dataNack(dataNack), .badCount(badCount), .arbLost(arbLost), .busFree(busFree),
		.restartReq(restartReq), .timeoutAbort(timeoutAbort), .transferBusy(transferBusy),
		.clockDivider(clockDivider), .ownAddress(ownAddress), .intr_n(intr_n));

	bisr_engine_model engine (.sys_clk(sys_clk), .go(go), .kind(kind), .dly(dly), .xferStart(xferStart),
		.xferDone(xferDone), .addrNack(addrNack), .dataNack(dataNack), .badCount(badCount),
		.arbLost(arbLost), .busFree(busFree));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (txValid === 1'b1) begin
			rdData <= txByte;
			rdCnt <= rdCnt + 1;
		end
		if (timeoutAbort === 1'b1) abortCnt <= abortCnt + 1;
		if (restartReq === 1'b1) restartSeen <= restartSeen + 1;
		if (restartReq === 1'b1 && busFree !== 1'b1) badRestart <= badRestart + 1;
	end

	// ----------------------------------------------------------------
	// Expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	function automatic logic [5:0] exp_oe(input logic [7:0] cfg, input logic [5:0] lat);
		logic [5:0] oe;
		oe = ~lat;
		for (int i = 0; i < 4; i++) begin
			if (cfg[2*i+:2] == `BISR_CFG_INPUT) oe[i] = 1'b0;
			if (cfg[2*i+:2] == `BISR_CFG_PUSH) oe[i] = 1'b1;
		end
		return oe;
	endfunction

	function automatic logic [7:0] exp_pin(input logic [7:0] cfg, input logic [5:0] lat, ext);
		logic [5:0] oe;
		oe = exp_oe(cfg, lat);
		return {2'b00, (oe & lat) | (~oe & ext)};
	endfunction

	task chk_reg(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk_bit(input string nm, input logic e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	// ----------------------------------------------------------------
	// Drivers, all launched at the falling edge
	// ----------------------------------------------------------------
	task send(input logic [7:0] b);
		rxValid = 1'b1;
		rxByte = b;
		@(negedge sys_clk);
	endtask

	task frame(input logic [7:0] c, a, v);
		frameActive = 1'b1;
		send(c);
		send(a);
		send(v);
		rxValid = 1'b0;
		repeat (2) @(negedge sys_clk);
		frameActive = 1'b0;
		@(negedge sys_clk);
	endtask

	task wr(input logic [7:0] a, v);
		frame(`BISR_CMD_WRITE, a, v);
	endtask

	task rd(input logic [7:0] a, e, input string nm);
		int c0;
		c0 = rdCnt;
		frame(`BISR_CMD_READ, a, 8'h5A);
		chk_bit({nm, " strobe"}, 1'b1, rdCnt == c0 + 1);
		chk_reg(nm, e, rdData);
	endtask

	task eng(input logic [2:0] k, input logic [7:0] t);
		kind = k;
		dly = t;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
	endtask

	task wait_low(input int lim);
		cnt = 0;
		while (intr_n !== 1'b0 && cnt < lim) begin
			@(negedge sys_clk);
			cnt++;
		end
	endtask

	task wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#1600000;
		failures++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{reset_n, frameActive, rxValid, go, rxByte, pinConfig, kind, dly, rdCnt} = '0;
		{abortCnt, restartSeen, badRestart, failures, n_checks} = '0;
		extLevel = 6'h2A;
		rnd = 8'h0C;
		repeat (8) @(negedge sys_clk);
		reset_n = 1'b1;
		chk_bit("intr_n", 1'b1, intr_n);
		chk_reg("pinOut", {2'b00, `BISR_RST_PINS}, {2'b00, pinOut});
		rd(`BISR_OFS_CLKDIV, `BISR_RST_CLKDIV, "clock divider");
		rd(`BISR_OFS_STATUS, `BISR_ST_OK, "status");
		rd(`BISR_OFS_TIMEOUT, `BISR_RST_TIMEOUT, "timeout");
		rd(`BISR_OFS_OWNADR, `BISR_RST_OWNADR, "own address");
		rd(8'h07, 8'h00, "unmapped");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			wr(`BISR_OFS_OWNADR, rnd & 8'hFE);
			chk_reg("ownAddress", rnd & 8'hFE, ownAddress);
			d = (i == 0) ? 8'h04 : (i == 1) ? `BISR_DIV_MIN : (i == 2) ? 8'hFF : rnd;
			wr(`BISR_OFS_CLKDIV, d);
			rd(`BISR_OFS_CLKDIV, d, "clock divider");
			chk_reg("clockDivider", (d < `BISR_DIV_MIN) ? `BISR_DIV_MIN : d, clockDivider);
			rnd = lfsr(rnd);
			pinConfig = rnd;
			rnd = lfsr(rnd);
			extLevel = rnd[5:0];
			rnd = lfsr(rnd);
			wr(`BISR_OFS_PINS, rnd);
			chk_reg("pinOut", {2'b00, rnd[5:0]}, {2'b00, pinOut});
			chk_reg("pinOe", {2'b00, exp_oe(pinConfig, rnd[5:0])}, {2'b00, pinOe});
			rd(`BISR_OFS_PINS, exp_pin(pinConfig, rnd[5:0], extLevel), "pin level");
		end
		wr(`BISR_OFS_STATUS, 8'h00);
		rd(`BISR_OFS_STATUS, `BISR_ST_OK, "status read only");
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			eng(k[2:0], 8'd40);
			repeat (3) @(negedge sys_clk);
			chk_bit("transferBusy", 1'b1, transferBusy);
			rd(`BISR_OFS_STATUS, `BISR_ST_BUSY, "status busy");
			chk_bit("intr_n busy", 1'b1, intr_n);
			wait_low(100);
			chk_bit("intr_n result", 1'b0, intr_n);
			rd(`BISR_OFS_STATUS, codes[k], "status result");
			chk_bit("intr_n cleared", 1'b1, intr_n);
		end
		$display("test results done");
		wr(`BISR_OFS_TIMEOUT, 8'h01);
		eng(3'h4, 8'd0);
		cnt = 0;
		while (timeoutAbort !== 1'b1 && cnt < 9000) begin
			@(negedge sys_clk);
			cnt++;
		end
		chk_bit("expiry time", 1'b1, cnt >= 511 * TD && cnt <= 513 * TD);
		repeat (2) @(negedge sys_clk);
		chk_bit("intr_n timeout", 1'b0, intr_n);
		chk_bit("transferBusy", 1'b0, transferBusy);
		rd(`BISR_OFS_STATUS, `BISR_ST_TIMEOUT, "status timeout");
		$display("test timeout done");
		wr(`BISR_OFS_TIMEOUT, 8'h00);
		cnt = abortCnt;
		eng(3'h4, 8'd0);
		repeat (520 * TD) @(negedge sys_clk);
		chk_bit("no expiry", 1'b1, abortCnt == cnt);
		rd(`BISR_OFS_STATUS, `BISR_ST_BUSY, "status disabled");
		eng(3'h6, 8'd20);
		repeat (40) @(negedge sys_clk);
		chk_bit("restart", 1'b1, restartSeen > 0);
		chk_bit("restart while taken", 1'b1, badRestart == 0);
		eng(3'h5, 8'd2);
		wait_low(50);
		rd(`BISR_OFS_STATUS, `BISR_ST_OK, "status finish");
		$display("test arbitration done");
		wrap_up;
	end
endmodule // test_bisr_regs
